// File: hw/bcsc_pkg.sv
/*
 * Package of the boost converter switch control block: timing constants,
 * frequency codes, command and status carriers.
 * Assumes a 100 MHz core clock; the period, filter and on/off cycle counts are derived from it here.
 */
// Function
// (R01) With the mode strap low the controller regulates by fixed-frequency pulse width modulation.
// (R02) With the mode strap high the controller regulates by constant on-time pulse frequency mode.
// (R03) The sawtooth runs at 150 kHz after reset and the frequency field selects up to 300 kHz.
// (R04) In fixed-frequency mode the gate is on while the error amplifier is above the ramp.
// (R05) In constant on-time mode the gate is on during on time and goes off on current limit or off time.
// (R06) On/off periods repeat while the output is below target and stop once it is above target.
// (R07) A current limit during on time keeps the oscillator off until the next on interval.
// (R08) Writing the converter enable bit to one starts a soft start.
// (R09) During soft start the duty begins small and grows gradually instead of jumping to full.
// (R10) Filtered over-current sets a flag that turns the gate off and stays while the condition lasts.
// (R11) Over-current lasting 16 switching cycles sets a shutdown latch that only reset clears.
// (R12) The current sense input is filtered by about 500 ns so that short glitches are ignored.
// (R13) The gate stays off below the supply power-off threshold until the power-on threshold is passed.
// (R14) Analog comparator outputs are synchronised before use and over-current persistence counts switching cycles.

`default_nettype none

package bcsc_pkg;

	// ***************************************************************
	// Clock and timing
	// ***************************************************************
	localparam int unsigned CLK_HZ         = 100_000_000;
	localparam int unsigned CLK_PERIOD_NS  = 10;
	localparam int unsigned CURRENT_SENSE_INPUT_FILT_NS = 500;
	localparam int unsigned CURRENT_SENSE_INPUT_FILT_CYC =
		(CURRENT_SENSE_INPUT_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TON_NS         = 2000;
	localparam int unsigned TOFF_NS        = 1000;
	localparam int unsigned TON_CYC        = TON_NS / CLK_PERIOD_NS;
	localparam int unsigned TOFF_CYC       = TOFF_NS / CLK_PERIOD_NS;
	localparam int unsigned OC_LIMIT_CYC   = 16;

	// ***************************************************************
	// Switching frequencies
	// ***************************************************************
	localparam int unsigned FREQ0_HZ = 150_000;
	localparam int unsigned FREQ1_HZ = 200_000;
	localparam int unsigned FREQ2_HZ = 250_000;
	localparam int unsigned FREQ3_HZ = 300_000;
	localparam int unsigned PER0_CYC = CLK_HZ / FREQ0_HZ;
	localparam int unsigned PER1_CYC = CLK_HZ / FREQ1_HZ;
	localparam int unsigned PER2_CYC = CLK_HZ / FREQ2_HZ;
	localparam int unsigned PER3_CYC = CLK_HZ / FREQ3_HZ;

	typedef enum logic [1:0] {
		BCSC_F150 = 2'h0,
		BCSC_F200 = 2'h1,
		BCSC_F250 = 2'h2,
		BCSC_F300 = 2'h3
	} bcsc_freq_t;

	// ***************************************************************
	// Reset values
	// ***************************************************************
	localparam logic       ENABLE_RST = 1'b0;
	localparam bcsc_freq_t FREQ_RST   = BCSC_F150;

	// ***************************************************************
	// Carriers
	// ***************************************************************
	typedef struct packed {
		logic       converter_enable_bit;
		bcsc_freq_t switch_frequency_field;
	} bcsc_ctrl_cmd_t;

	typedef struct packed {
		logic pfm_mode;
		logic running;
		logic soft_start;
		logic over_current;
		logic uvlo;
		logic shutdown_latched;
	} bcsc_status_t;

endpackage : bcsc_pkg

`default_nettype wire

// File: hw/bcsc_sync_filter.sv
/*
 * Two-flop synchroniser followed by a stability filter for one
 * asynchronous comparator or pad level.
 * Assumes rst_n_in is already synchronous to clk_in.
 */
`timescale 1ns/1ns
`default_nettype none

module bcsc_sync_filter #(
	parameter int unsigned STABLE_CYC = 1,
	parameter logic        RST_VAL    = 1'b0
) (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic clk_en_in,
	// Level
	input  wire logic async_in,
	output logic      level_out
);

	localparam int unsigned CW = $clog2(STABLE_CYC + 1);

	logic          meta_ff;
	logic          sync_ff;
	logic          level_ff;
	logic [CW-1:0] cnt_ff;
	logic          nxt_level;
	logic [CW-1:0] nxt_cnt;

	// ***************************************************************
	// Level follows only after STABLE_CYC agreeing samples
	// ***************************************************************
	always_comb begin
		nxt_level = level_ff;
		nxt_cnt   = '0;
		if (sync_ff != level_ff) begin
			if (cnt_ff >= CW'(STABLE_CYC - 1)) begin
				nxt_level = sync_ff;
			end else begin
				nxt_cnt = cnt_ff + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_ff  <= RST_VAL;
			sync_ff  <= RST_VAL;
			level_ff <= RST_VAL;
			cnt_ff   <= '0;
		end else if (clk_en_in) begin
			meta_ff  <= async_in;
			sync_ff  <= meta_ff;
			level_ff <= nxt_level;
			cnt_ff   <= nxt_cnt;
		end
	end

	assign level_out = level_ff;

endmodule : bcsc_sync_filter

`default_nettype wire

// File: hw/bcsc_switch_ctrl.sv
/*
 * Boost converter switch control: PWM and constant on-time regulation,
 * soft start, over-current flag and shutdown latch, supply lockout.
 * Assumes comparator and pad inputs are asynchronous and the command
 * strobe comes from logic on clk_in.
 */
`timescale 1ns/1ns
`default_nettype none

module bcsc_switch_ctrl #(
	parameter int unsigned CNT_W   = 10,
	parameter int unsigned SS_STEP = 1
) (
	// Clock, reset, enable
	input  wire logic                    clk_in,
	input  wire logic                    reset_n_in,
	input  wire logic                    clk_en_in,
	// Strap pad
	input  wire logic                    mode_strap_in,
	// Converter control command
	input  wire logic                    cmd_wr_in,
	input  wire bcsc_pkg::bcsc_ctrl_cmd_t cmd_in,
	// Analog comparators
	input  wire logic                    error_amp_above_ramp_in,
	input  wire logic                    feedback_below_target_in,
	input  wire logic                    current_sense_over_in,
	input  wire logic                    supply_above_off_in,
	input  wire logic                    supply_above_on_in,
	// Gate and ramp
	output logic                         gate_drive_out,
	output logic [CNT_W-1:0]             ramp_count_out,
	// Status
	output bcsc_pkg::bcsc_status_t       status_out
);

	typedef enum logic [2:0] {
		ST_OFF,
		ST_PWM,
		ST_PFM_IDLE,
		ST_PFM_ON,
		ST_PFM_OFF
	} bcsc_state_t;

	// ***************************************************************
	// Reset release
	// ***************************************************************
	logic rst_meta_ff;
	logic rst_n_ff;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rst_meta_ff <= 1'b0;
			rst_n_ff    <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n_ff    <= rst_meta_ff;
		end
	end

	// ***************************************************************
	// Synchronised inputs
	// ***************************************************************
	logic strap_pfm;
	logic amp_above;
	logic below_target;
	logic oc_filt;
	logic sup_above_off;
	logic sup_above_on;

	bcsc_sync_filter #(.STABLE_CYC(1), .RST_VAL(1'b0)) u_strap (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_ff),
		.clk_en_in(clk_en_in),
		.async_in (mode_strap_in),
		.level_out(strap_pfm)
	); // see (R14)

	bcsc_sync_filter #(.STABLE_CYC(1), .RST_VAL(1'b0)) u_amp (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_ff),
		.clk_en_in(clk_en_in),
		.async_in (error_amp_above_ramp_in),
		.level_out(amp_above)
	); // see (R14)

	bcsc_sync_filter #(.STABLE_CYC(1), .RST_VAL(1'b0)) u_reg (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_ff),
		.clk_en_in(clk_en_in),
		.async_in (feedback_below_target_in),
		.level_out(below_target)
	); // see (R14)

	bcsc_sync_filter #(
		.STABLE_CYC(bcsc_pkg::CURRENT_SENSE_INPUT_FILT_CYC),
		.RST_VAL   (1'b0)
	) u_current_sense_input (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_ff),
		.clk_en_in(clk_en_in),
		.async_in (current_sense_over_in),
		.level_out(oc_filt)
	); // see (R12)

	bcsc_sync_filter #(.STABLE_CYC(1), .RST_VAL(1'b0)) u_sup_off (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_ff),
		.clk_en_in(clk_en_in),
		.async_in (supply_above_off_in),
		.level_out(sup_above_off)
	);

	bcsc_sync_filter #(.STABLE_CYC(1), .RST_VAL(1'b0)) u_sup_on (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_ff),
		.clk_en_in(clk_en_in),
		.async_in (supply_above_on_in),
		.level_out(sup_above_on)
	);

	// ***************************************************************
	// Helpers
	// ***************************************************************
	function automatic logic [CNT_W-1:0] period_cyc(input bcsc_pkg::bcsc_freq_t f);
		case (f)
			bcsc_pkg::BCSC_F150: period_cyc = CNT_W'(bcsc_pkg::PER0_CYC);
			bcsc_pkg::BCSC_F200: period_cyc = CNT_W'(bcsc_pkg::PER1_CYC);
			bcsc_pkg::BCSC_F250: period_cyc = CNT_W'(bcsc_pkg::PER2_CYC);
			bcsc_pkg::BCSC_F300: period_cyc = CNT_W'(bcsc_pkg::PER3_CYC);
			default:             period_cyc = CNT_W'(bcsc_pkg::PER0_CYC);
		endcase
	endfunction : period_cyc

	function automatic logic [CNT_W-1:0] sat_step(input logic [CNT_W-1:0] v,
	                                              input logic [CNT_W-1:0] lim);
		if (v >= lim - CNT_W'(SS_STEP)) begin
			sat_step = lim;
		end else begin
			sat_step = v + CNT_W'(SS_STEP);
		end
	endfunction : sat_step

	localparam logic [CNT_W-1:0] TON_C  = CNT_W'(bcsc_pkg::TON_CYC);
	localparam logic [CNT_W-1:0] TOFF_C = CNT_W'(bcsc_pkg::TOFF_CYC);
	localparam logic [4:0]       OC_LIM = 5'(bcsc_pkg::OC_LIMIT_CYC);

	// ***************************************************************
	// Control state
	// ***************************************************************
	bcsc_state_t          state_ff,  nxt_state;
	logic                 enable_ff, nxt_enable;
	bcsc_pkg::bcsc_freq_t freq_ff,   nxt_freq;
	logic                 pfm_ff,    nxt_pfm;
	logic                 uvlo_ok_ff, nxt_uvlo_ok;
	logic                 latch_ff,  nxt_latch;
	logic [4:0]           oc_cnt_ff, nxt_oc_cnt;
	logic [CNT_W-1:0]     cnt_ff,    nxt_cnt;
	logic [CNT_W-1:0]     ss_ff,     nxt_ss;
	logic                 gate_ff,   nxt_gate;
	logic [CNT_W-1:0]     period;
	logic                 run_ok;
	logic                 cycle_start;

	assign period = period_cyc(freq_ff); // see (R03)
	assign run_ok = enable_ff && uvlo_ok_ff && !latch_ff; // see (R11) see (R13)

	always_comb begin
		nxt_state   = state_ff;
		nxt_enable  = enable_ff;
		nxt_freq    = freq_ff;
		nxt_pfm     = pfm_ff;
		nxt_latch   = latch_ff;
		nxt_oc_cnt  = oc_cnt_ff;
		nxt_cnt     = cnt_ff;
		nxt_ss      = ss_ff;
		nxt_gate    = 1'b0;
		cycle_start = 1'b0;
		nxt_uvlo_ok = uvlo_ok_ff;

		// Supply lockout with hysteresis
		if (!sup_above_off) begin
			nxt_uvlo_ok = 1'b0; // see (R13)
		end else if (sup_above_on) begin
			nxt_uvlo_ok = 1'b1; // see (R13)
		end

		// Converter control command
		if (cmd_wr_in) begin
			nxt_enable = cmd_in.converter_enable_bit; // see (R08)
			nxt_freq   = cmd_in.switch_frequency_field; // see (R03)
		end

		case (state_ff)
			ST_OFF: begin
				nxt_cnt = '0;
				nxt_ss  = '0; // see (R08)
				nxt_pfm = strap_pfm;
				if (run_ok) begin
					nxt_state = strap_pfm ? ST_PFM_IDLE : ST_PWM; // see (R01) see (R02)
				end
			end
			ST_PWM: begin
				if (cnt_ff >= period - 1'b1) begin
					nxt_cnt     = '0;
					nxt_ss      = sat_step(ss_ff, period); // see (R09)
					cycle_start = 1'b1;
				end else begin
					nxt_cnt = cnt_ff + 1'b1;
				end
				nxt_gate = amp_above && (cnt_ff < ss_ff) && !oc_filt; // see (R04) see (R09) see (R10)
			end
			ST_PFM_IDLE: begin
				nxt_cnt = '0;
				if (below_target) begin
					nxt_state   = ST_PFM_ON; // see (R06)
					cycle_start = 1'b1;
					nxt_gate    = !oc_filt && (ss_ff != '0);
				end
			end
			ST_PFM_ON: begin
				if (oc_filt || cnt_ff >= TON_C - 1'b1) begin
					nxt_state = ST_PFM_OFF; // see (R05) see (R07)
					nxt_cnt   = '0;
					nxt_ss    = sat_step(ss_ff, TON_C); // see (R09)
				end else begin
					nxt_cnt  = cnt_ff + 1'b1;
					nxt_gate = (cnt_ff + 1'b1) < ss_ff; // see (R05) see (R09)
				end
			end
			ST_PFM_OFF: begin
				if (cnt_ff >= TOFF_C - 1'b1) begin
					nxt_cnt = '0;
					if (below_target) begin
						nxt_state   = ST_PFM_ON; // see (R06)
						cycle_start = 1'b1;
						nxt_gate    = !oc_filt && (ss_ff != '0);
					end else begin
						nxt_state = ST_PFM_IDLE; // see (R06)
					end
				end else begin
					nxt_cnt = cnt_ff + 1'b1;
				end
			end
			default: begin
				nxt_state = ST_OFF;
			end
		endcase

		// Over-current persistence in switching cycles
		if (!oc_filt) begin
			nxt_oc_cnt = '0; // see (R14)
		end else if (cycle_start && oc_cnt_ff < OC_LIM) begin
			nxt_oc_cnt = oc_cnt_ff + 1'b1; // see (R11)
		end
		if (nxt_oc_cnt >= OC_LIM) begin
			nxt_latch = 1'b1; // see (R11)
		end

		if (!run_ok || nxt_latch || state_ff == ST_OFF) begin
			nxt_gate = 1'b0; // see (R11) see (R13)
			if (state_ff != ST_OFF) begin
				nxt_state = ST_OFF;
			end
		end
		if (oc_filt) begin
			nxt_gate = 1'b0; // see (R10)
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			state_ff   <= ST_OFF;
			enable_ff  <= bcsc_pkg::ENABLE_RST;
			freq_ff    <= bcsc_pkg::FREQ_RST; // see (R03)
			pfm_ff     <= 1'b0;
			uvlo_ok_ff <= 1'b0;
			latch_ff   <= 1'b0; // see (R11)
			oc_cnt_ff  <= '0;
			cnt_ff     <= '0;
			ss_ff      <= '0;
			gate_ff    <= 1'b0;
		end else if (clk_en_in) begin
			state_ff   <= nxt_state;
			enable_ff  <= nxt_enable;
			freq_ff    <= nxt_freq;
			pfm_ff     <= nxt_pfm;
			uvlo_ok_ff <= nxt_uvlo_ok;
			latch_ff   <= nxt_latch;
			oc_cnt_ff  <= nxt_oc_cnt;
			cnt_ff     <= nxt_cnt;
			ss_ff      <= nxt_ss;
			gate_ff    <= nxt_gate;
		end
	end

	// ***************************************************************
	// Outputs
	// ***************************************************************
	logic                  ss_active;
	bcsc_pkg::bcsc_status_t status_ff;

	assign ss_active = (state_ff == ST_PWM) ? (ss_ff < period) :
	                   (state_ff != ST_OFF) ? (ss_ff < TON_C) : 1'b0;

	always_ff @(posedge clk_in or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			status_ff <= '0;
		end else if (clk_en_in) begin
			status_ff.pfm_mode         <= pfm_ff;
			status_ff.running          <= (state_ff != ST_OFF);
			status_ff.soft_start       <= ss_active;
			status_ff.over_current     <= oc_filt; // see (R10)
			status_ff.uvlo             <= !uvlo_ok_ff;
			status_ff.shutdown_latched <= latch_ff;
		end
	end

	assign gate_drive_out = gate_ff;
	assign ramp_count_out = cnt_ff;
	assign status_out     = status_ff;

endmodule : bcsc_switch_ctrl

`default_nettype wire

// File: verification/bcsc_props.sv
/* Checker of bcsc_switch_ctrl: gate, ramp and status relations.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module bcsc_props #(
	parameter int unsigned CNT_W   = 10,
	parameter int unsigned SS_STEP = 1
) (
	// Clock and reset
	input wire logic                   clk_in,
	input wire logic                   reset_n_in,
	// Watched signals
	input wire logic                   current_sense_over_in,
	input wire logic                   gate_drive_out,
	input wire logic [CNT_W-1:0]       ramp_count_out,
	input wire bcsc_pkg::bcsc_status_t status_out
);
	localparam int unsigned PER_MAX = bcsc_pkg::PER0_CYC;
	logic [8:0] run_ff;
	logic [8:0] nxt_run;

	// Length of the current gate-on run
	always_comb nxt_run = gate_drive_out ? run_ff + 9'h001 : 9'h000;
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) run_ff <= 9'h000;
		else run_ff <= nxt_run;
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);

	a_oc_gate_off: assert property (status_out.over_current |-> !gate_drive_out)
		else $error("gate on while over-current flagged");
	a_latch_hold: assert property (status_out.shutdown_latched
		|=> status_out.shutdown_latched)
		else $error("shutdown latch dropped");
	a_latch_stops: assert property ($past(status_out.shutdown_latched, 2)
		|-> !gate_drive_out && !status_out.running)
		else $error("converter active while latched");
	a_uvlo_gate_off: assert property (status_out.uvlo && $past(status_out.uvlo)
		|-> !gate_drive_out)
		else $error("gate on under lockout");
	a_ramp_bound: assert property (ramp_count_out < PER_MAX)
		else $error("ramp beyond longest period");
	a_pfm_on_max: assert property (status_out.pfm_mode
		|-> run_ff <= 9'(bcsc_pkg::TON_CYC))
		else $error("on interval too long");
	a_pfm_off_min: assert property ($fell(gate_drive_out) && status_out.pfm_mode
		|=> !gate_drive_out [*8])
		else $error("off interval too short");
	a_ss_zero_duty: assert property ($rose(status_out.running) && !status_out.pfm_mode
		|-> !gate_drive_out [*8])
		else $error("full duty at start");
	a_glitch_rej: assert property ($rose(status_out.over_current)
		|-> $past(current_sense_over_in, 20))
		else $error("over-current from short pulse");
	a_idle_gate: assert property (!status_out.running && !$past(status_out.running)
		|-> !gate_drive_out)
		else $error("gate on while stopped");

	c_latch: cover property ($rose(status_out.shutdown_latched));
	c_pfm_run: cover property ($rose(status_out.running) && status_out.pfm_mode);
	c_uvlo_out: cover property ($fell(status_out.uvlo));
endmodule : bcsc_props

bind bcsc_switch_ctrl bcsc_props #(.CNT_W(CNT_W), .SS_STEP(SS_STEP)) props_u (
	.clk_in(clk_in), .reset_n_in(reset_n_in), .current_sense_over_in(current_sense_over_in),
	.gate_drive_out(gate_drive_out), .ramp_count_out(ramp_count_out), .status_out(status_out));
`default_nettype wire

// File: verification/bcsc_fet_model.sv
/* Switching transistor and inductor model: sense trips after a set on time.
   Assumes the gate is sampled on the core clock. */
`timescale 1ns/1ns
`default_nettype none
module bcsc_fet_model (
	// Clock and gate
	input wire logic       clk_in,
	input wire logic       gate_in,
	// Bench controls
	input wire logic       fault_in,
	input wire logic       demand_in,
	input wire logic [9:0] ilim_in,
	// Comparators
	output logic           sense_over_out,
	output logic           below_target_out
);
	logic [9:0] on_ff;
	// Inductor current grows while on, zero limit means only fault_in trips
	always_ff @(posedge clk_in) on_ff <= gate_in ? on_ff + 10'h001 : 10'h000;
	assign sense_over_out   = fault_in | (ilim_in != 10'h000 && on_ff >= ilim_in);
	assign below_target_out = demand_in;
endmodule : bcsc_fet_model
`default_nettype wire

// File: verification/testbench.sv
/* Self-checking bench of bcsc_switch_ctrl with the transistor model.
   Assumes design, checker and model are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic                     clk_in     = 1'b0;
	logic                     reset_n_in = 1'b0;
	logic                     clk_en     = 1'b1;
	logic                     strap      = 1'b0;
	logic                     cmd_wr     = 1'b0;
	bcsc_pkg::bcsc_ctrl_cmd_t cmd        = '0;
	logic                     amp_above  = 1'b0;
	logic                     sup_off    = 1'b1;
	logic                     sup_on     = 1'b1;
	logic                     fault      = 1'b0;
	logic                     demand     = 1'b0;
	logic [9:0]               ilim       = 10'h000;
	logic                     gate;
	logic                     below;
	logic                     sense;
	logic [9:0]               ramp;
	bcsc_pkg::bcsc_status_t   st;
	int                       err_count  = 0;
	int                       checks     = 0;
	int per [4] = '{bcsc_pkg::PER0_CYC, bcsc_pkg::PER1_CYC, bcsc_pkg::PER2_CYC, bcsc_pkg::PER3_CYC};

	always #5 clk_in = ~clk_in;

	bcsc_switch_ctrl #(.CNT_W(10), .SS_STEP(100)) dut_u (
		.clk_in(clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en), .mode_strap_in(strap),
		.cmd_wr_in(cmd_wr), .cmd_in(cmd), .error_amp_above_ramp_in(amp_above),
		.feedback_below_target_in(below), .current_sense_over_in(sense),
		.supply_above_off_in(sup_off), .supply_above_on_in(sup_on),
		.gate_drive_out(gate), .ramp_count_out(ramp), .status_out(st));
	bcsc_fet_model fet_u (.clk_in(clk_in), .gate_in(gate), .fault_in(fault), .demand_in(demand),
		.ilim_in(ilim), .sense_over_out(sense), .below_target_out(below));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(negedge clk_in);
	endtask : tick
	task automatic command(input logic en, input logic [1:0] f);
		cmd_wr = 1'b1;
		cmd = {en, f};
		tick(1);
		cmd_wr = 1'b0;
		tick(4);
	endtask : command
	task automatic run_len(input logic v, output int n);
		n = 0;
		while (gate === v && n < 2000) begin
			n++;
			tick(1);
		end
	endtask : run_len
	task automatic start(input logic mode, input logic [1:0] f);
		command(1'b0, f);
		strap = mode;
		tick(10);
		command(1'b1, f);
		check(16'(st.running), 16'h0001);
		check(16'(st.pfm_mode), 16'(mode));
	endtask : start

	// ***************************************************************
	// Scenarios
	// ***************************************************************
	task automatic t_pwm();
		int hi;
		logic [9:0] mx;
		amp_above = 1'b1;
		for (int f = 0; f < 4; f++) begin
			start(1'b0, f[1:0]);
			hi = 0;
			mx = 10'h000;
			repeat (per[f] - 20) begin
				hi += gate;
				tick(1);
			end
			check(16'(hi), 16'h0000);
			check(16'(st.soft_start), 16'h0001);
			tick(per[f] * 8);
			check(16'(st.soft_start), 16'h0000);
			hi = 0;
			repeat (per[f] + 2) begin
				if (ramp > mx) mx = ramp;
				hi += gate;
				tick(1);
			end
			check(16'(mx), 16'(per[f] - 1));
			check(16'(hi > per[f] / 2), 16'h0001);
		end
		amp_above = 1'b0;
		tick(10);
		run_len(1'b0, hi);
		check(16'(hi), 16'h07D0);
	endtask : t_pwm
	task automatic t_pfm();
		int n;
		start(1'b1, 2'h0);
		demand = 1'b1;
		tick(2000);
		// Skip any partial interval so that the measured runs are whole
		run_len(1'b1, n);
		run_len(1'b0, n);
		run_len(1'b1, n);
		check(16'(n), 16'(bcsc_pkg::TON_CYC));
		run_len(1'b0, n);
		check(16'(n), 16'(bcsc_pkg::TOFF_CYC));
		ilim = 10'h01E;
		tick(400);
		run_len(1'b1, n);
		run_len(1'b0, n);
		run_len(1'b1, n);
		check(16'(n < bcsc_pkg::TON_CYC), 16'h0001);
		run_len(1'b0, n);
		check(16'(n >= bcsc_pkg::TOFF_CYC), 16'h0001);
		ilim = 10'h000;
		demand = 1'b0;
		tick(400);
		run_len(1'b0, n);
		check(16'(n), 16'h07D0);
	endtask : t_pfm
	task automatic t_oc();
		start(1'b0, 2'h3);
		amp_above = 1'b1;
		tick(3000);
		fault = 1'b1;
		tick(30);
		fault = 1'b0;
		tick(20);
		check(16'(st.over_current), 16'h0000);
		tick(100);
		fault = 1'b1;
		tick(70);
		check(16'(st.over_current), 16'h0001);
		check(16'(gate), 16'h0000);
		tick((bcsc_pkg::OC_LIMIT_CYC - 2) * bcsc_pkg::PER3_CYC);
		check(16'(st.shutdown_latched), 16'h0000);
		tick(3 * bcsc_pkg::PER3_CYC + 100);
		check(16'(st.shutdown_latched), 16'h0001);
		fault = 1'b0;
		tick(100);
		command(1'b1, 2'h3);
		tick(700);
		check(16'(st.running), 16'h0000);
		reset_n_in = 1'b0;
		tick(3);
		reset_n_in = 1'b1;
		tick(10);
		check(16'(st.shutdown_latched), 16'h0000);
	endtask : t_oc
	task automatic t_uvlo();
		int n;
		start(1'b0, 2'h0);
		tick(5000);
		sup_off = 1'b0;
		sup_on = 1'b0;
		tick(10);
		check(16'({st.uvlo, gate}), 16'h0002);
		sup_off = 1'b1;
		tick(100);
		check(16'(st.uvlo), 16'h0001);
		sup_on = 1'b1;
		tick(10);
		check(16'({st.uvlo, st.running}), 16'h0001);
		run_len(1'b0, n);
		check(16'(n > 600), 16'h0001);
		// Clock enable low must freeze the ramp, and it resumes afterwards
		n = ramp;
		clk_en = 1'b0;
		tick(20);
		check(16'(ramp), 16'(n));
		clk_en = 1'b1;
		tick(3);
		check(16'(ramp), 16'(n + 3));
	endtask : t_uvlo

	task automatic print_verdict();
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict

	initial begin
		tick(20);
		check(16'({gate, ramp}), 16'h0000);
		check(16'(st), 16'h0000);
		reset_n_in = 1'b1;
		tick(10);
		check(16'(st.uvlo), 16'h0000);
		t_pwm();
		t_pfm();
		t_oc();
		t_uvlo();
		print_verdict();
	end
	initial begin
		#1_000_000;
		err_count++;
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
